// [blfr_map.svh]
`ifndef BLFR_MAP_SVH
`define BLFR_MAP_SVH

// register addresses (5-bit address space of the single-wire interface)
`define BLFR_ADDR_LEVEL 5'h00
`define BLFR_ADDR_SINKS 5'h01
`define BLFR_ADDR_REGA 5'h02
`define BLFR_ADDR_REGB 5'h03
`define BLFR_ADDR_RAMP 5'h04

// field positions
`define BLFR_LEVEL_MSB 4
`define BLFR_SINKS_MSB 4
`define BLFR_SINKS_LSB 1
`define BLFR_REGA_MSB 3
`define BLFR_REGB_MSB 2
`define BLFR_RATE_MSB 2
`define BLFR_RATE_LSB 1
`define BLFR_FADE_EN_BIT 0

// reset values
`define BLFR_RST_LEVEL 5'h00
`define BLFR_RST_SINKS 4'h0
`define BLFR_RST_REGA 4'h0
`define BLFR_RST_REGB 3'h0
`define BLFR_RST_RATE 2'h0

// timing
`define BLFR_CLK_HZ 50000000
`define BLFR_TICK_US 1000
`define BLFR_TICK_CYCLES ((`BLFR_CLK_HZ / 1000000) * `BLFR_TICK_US)
`define BLFR_STEP_MS_R0 32
`define BLFR_STEP_MS_R1 24
`define BLFR_STEP_MS_R2 16
`define BLFR_STEP_MS_R3 8

`endif

// [blfr_pkg.sv]
package blfr_pkg;
  typedef enum logic [1:0] {
    BLFR_RATE_32MS,
    BLFR_RATE_24MS,
    BLFR_RATE_16MS,
    BLFR_RATE_8MS
  } blfr_rate_t;

  typedef enum logic {
    BLFR_IDLE,
    BLFR_FADING
  } blfr_state_t;

  // current in units of 0.5 mA
  typedef logic [5:0] blfr_halfma_t;
endpackage

// [blfr_tick.sv]
`include "blfr_map.svh"

module blfr_tick #(
  parameter int unsigned TICK_CYCLES = `BLFR_TICK_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  // control
  input wire logic restart_i,
  // tick output
  output logic tick_o
);
  localparam int unsigned CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (restart_i) begin
      nxt_cnt = '0;
    end else if (cnt_ff == LAST) begin
      nxt_cnt = '0;
      nxt_tick = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + CW'(1);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (clk_en_i) begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;
endmodule

// [blfr_regs.sv]
// Summary of operation
// [RQ1] level code zero gives no current; codes one to three are reserved, no current
// [RQ2] codes 4-13 give 0.5-5 mA by halves, 14-29 6-21 mA, 30 23, 31 25
// [RQ3] all enabled sinks carry the same current from the shared level code
// [RQ4] a sink stays off unless its enable bit is set
// [RQ5] enable bits D1..D4 drive sinks one to four, active high, reset low
// [RQ6] regulator A code: 0 off, 1-10 3.3-2.4 V, 11 2.2 V, 12-15 1.8-1.5 V
// [RQ7] regulator B code: 0 off, 1-7 1.8-1.2 V
// [RQ8] fade rate 00/01/10/11 selects 32/24/16/8 ms per step
// [RQ9] fade steps equal the code difference, one count per step
// [RQ10] with fade enabled a new level starts a stepping fade to the target
// [RQ11] level writes are refused while a fade runs; the fade keeps its target
// [RQ12] clearing fade enable mid-fade jumps the effective code to the programmed level
// [RQ13] with fade disabled a new level takes effect at once
// [RQ14] rate may change mid-fade; later steps use the new interval
// [RQ15] all registers are write-only; no read path exists
// [RQ16] host writes zero into undefined bit positions
// [RQ17] step interval counts a millisecond tick, restarted when a fade starts
`include "blfr_map.svh"

module blfr_regs #(
  parameter int unsigned TICK_CYCLES = `BLFR_TICK_CYCLES
) (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  // write port from the single-wire decoder
  input wire logic [4:0] wr_addr_i,
  input wire logic [5:0] wr_data_i,
  input wire logic wr_stb_i,
  // sink controls
  output logic [4:0] level_code_o,
  output blfr_pkg::blfr_halfma_t sink_halfma_o,
  output logic [3:0] sink_enables_o,
  output logic [3:0] sink_on_o,
  // regulator controls
  output logic [3:0] regulator_a_code_o,
  output logic [6:0] regulator_a_cv_o,
  output logic [2:0] regulator_b_code_o,
  output logic [4:0] regulator_b_cv_o,
  // fade status
  output logic fading_o
);
  import blfr_pkg::*;

  // regulator voltages are carried in units of 0.1 V, zero meaning off
  function automatic blfr_halfma_t level_to_halfma(input logic [4:0] code);
    blfr_halfma_t r;
    r = '0;
    if (code < 5'h04) begin
      r = '0; // [RQ1]
    end else if (code <= 5'h0D) begin
      r = 6'(code) - 6'h03; // [RQ2]
    end else if (code <= 5'h1D) begin
      r = (6'(code) - 6'h08) << 1; // [RQ2]
    end else if (code == 5'h1E) begin
      r = 6'h2E; // [RQ2]
    end else begin
      r = 6'h32; // [RQ2]
    end
    return r;
  endfunction

  function automatic logic [6:0] rega_to_cv(input logic [3:0] code);
    logic [6:0] v;
    v = '0;
    if (code == 4'h0) begin
      v = '0; // [RQ6]
    end else if (code <= 4'hA) begin
      v = 7'h22 - 7'(code); // [RQ6]
    end else if (code == 4'hB) begin
      v = 7'h16; // [RQ6]
    end else begin
      v = 7'h1E - 7'(code); // [RQ6]
    end
    return v;
  endfunction

  function automatic logic [15:0] rate_ms(input blfr_rate_t rate);
    logic [15:0] m;
    m = 16'h0000;
    unique case (rate)
      BLFR_RATE_32MS: m = 16'(`BLFR_STEP_MS_R0); // [RQ8]
      BLFR_RATE_24MS: m = 16'(`BLFR_STEP_MS_R1); // [RQ8]
      BLFR_RATE_16MS: m = 16'(`BLFR_STEP_MS_R2); // [RQ8]
      BLFR_RATE_8MS: m = 16'(`BLFR_STEP_MS_R3); // [RQ8]
    endcase
    return m;
  endfunction

  function automatic logic [4:0] regb_to_cv(input logic [2:0] code);
    logic [4:0] v;
    v = '0;
    if (code == 3'h0) begin
      v = '0; // [RQ7]
    end else begin
      v = 5'h13 - 5'(code); // [RQ7]
    end
    return v;
  endfunction

  // reset synchroniser: release lands on one edge for every flop behind it
  logic [1:0] rst_sync_ff;
  logic [1:0] nxt_rst_sync;
  logic rstn;
  always_comb begin
    nxt_rst_sync = {rst_sync_ff[0], 1'b1};
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= nxt_rst_sync;
    end
  end
  assign rstn = rst_sync_ff[1];

  logic [4:0] level_ff;
  logic [4:0] nxt_level;
  logic [4:0] eff_ff;
  logic [4:0] nxt_eff;
  logic [3:0] sinks_ff;
  logic [3:0] nxt_sinks;
  logic [3:0] rega_ff;
  logic [3:0] nxt_rega;
  logic [2:0] regb_ff;
  logic [2:0] nxt_regb;
  blfr_rate_t rate_ff;
  blfr_rate_t nxt_rate;
  logic fade_en_ff;
  logic nxt_fade_en;
  blfr_state_t state_ff;
  blfr_state_t nxt_state;
  logic [15:0] ms_ff;
  logic [15:0] nxt_ms;
  logic restart;
  logic tick;

  // derived outputs registered
  blfr_halfma_t halfma_ff;
  blfr_halfma_t nxt_halfma;
  logic [3:0] on_ff;
  logic [3:0] nxt_on;
  logic [6:0] rega_cv_ff;
  logic [6:0] nxt_rega_cv;
  logic [4:0] regb_cv_ff;
  logic [4:0] nxt_regb_cv;
  logic fading_ff;
  logic nxt_fading;

  // one shared tick; restarting it on a fade start makes the first step a full interval
  blfr_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn),
    .clk_en_i(clk_en_i),
    .restart_i(restart),
    .tick_o(tick)
  );

  // one write port, so a ramp write and a level write never share a cycle
  logic wr_level, wr_sinks, wr_rega, wr_regb, wr_ramp;
  assign wr_level = wr_stb_i && (wr_addr_i == `BLFR_ADDR_LEVEL);
  assign wr_sinks = wr_stb_i && (wr_addr_i == `BLFR_ADDR_SINKS);
  assign wr_rega = wr_stb_i && (wr_addr_i == `BLFR_ADDR_REGA);
  assign wr_regb = wr_stb_i && (wr_addr_i == `BLFR_ADDR_REGB);
  assign wr_ramp = wr_stb_i && (wr_addr_i == `BLFR_ADDR_RAMP);

  // plain configuration registers; reserved bits are simply dropped [RQ16]
  always_comb begin
    nxt_sinks = sinks_ff;
    nxt_rega = rega_ff;
    nxt_regb = regb_ff;
    nxt_rate = rate_ff;
    nxt_fade_en = fade_en_ff;
    if (wr_sinks) begin
      nxt_sinks = wr_data_i[`BLFR_SINKS_MSB:`BLFR_SINKS_LSB]; // [RQ5]
    end
    if (wr_rega) begin
      nxt_rega = wr_data_i[`BLFR_REGA_MSB:0];
    end
    if (wr_regb) begin
      nxt_regb = wr_data_i[`BLFR_REGB_MSB:0];
    end
    if (wr_ramp) begin
      nxt_rate = blfr_rate_t'(wr_data_i[`BLFR_RATE_MSB:`BLFR_RATE_LSB]); // [RQ14]
      nxt_fade_en = wr_data_i[`BLFR_FADE_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn) begin
    if (!rstn) begin
      sinks_ff <= `BLFR_RST_SINKS;
      rega_ff <= `BLFR_RST_REGA;
      regb_ff <= `BLFR_RST_REGB;
      rate_ff <= blfr_rate_t'(`BLFR_RST_RATE);
      fade_en_ff <= 1'b0;
    end else if (clk_en_i) begin
      sinks_ff <= nxt_sinks;
      rega_ff <= nxt_rega;
      regb_ff <= nxt_regb;
      rate_ff <= nxt_rate;
      fade_en_ff <= nxt_fade_en;
    end
  end

  // fade engine
  always_comb begin
    nxt_level = level_ff;
    nxt_eff = eff_ff;
    nxt_state = state_ff;
    nxt_ms = ms_ff;
    restart = 1'b0;
    unique case (state_ff)
      BLFR_IDLE: begin
        if (wr_level) begin
          nxt_level = wr_data_i[`BLFR_LEVEL_MSB:0];
          // fade enable as it stands after this cycle's ramp write
          if (nxt_fade_en && (wr_data_i[`BLFR_LEVEL_MSB:0] != eff_ff)) begin
            nxt_state = BLFR_FADING; // [RQ10]
            nxt_ms = 16'h0000;
            restart = 1'b1; // [RQ17]
          end else begin
            nxt_eff = wr_data_i[`BLFR_LEVEL_MSB:0]; // [RQ13]
          end
        end
      end
      BLFR_FADING: begin
        // level writes ignored here; the target stands [RQ11]
        if (!nxt_fade_en) begin
          nxt_eff = level_ff; // [RQ12]
          nxt_state = BLFR_IDLE;
        end else if (tick) begin
          // compare against the live rate so a mid-fade change applies at once [RQ14]
          // an interval already past a newly lowered rate steps on this tick
          if (ms_ff + 16'h0001 >= rate_ms(rate_ff)) begin // [RQ17]
            nxt_ms = 16'h0000;
            // one count per step, so steps equal the code distance [RQ9]
            nxt_eff = (level_ff > eff_ff) ? eff_ff + 5'h01 : eff_ff - 5'h01; // [RQ10]
            if (nxt_eff == level_ff) begin
              nxt_state = BLFR_IDLE;
            end
          end else begin
            nxt_ms = ms_ff + 16'h0001;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn) begin
    if (!rstn) begin
      level_ff <= `BLFR_RST_LEVEL;
      eff_ff <= `BLFR_RST_LEVEL;
      state_ff <= BLFR_IDLE;
      ms_ff <= 16'h0000;
    end else if (clk_en_i) begin
      level_ff <= nxt_level;
      eff_ff <= nxt_eff;
      state_ff <= nxt_state;
      ms_ff <= nxt_ms;
    end
  end

  // decode from next values so decoded outputs move on the same edge as the codes
  always_comb begin
    nxt_halfma = level_to_halfma(nxt_eff); // [RQ3]
    nxt_on = nxt_sinks & {4{nxt_halfma != '0}}; // [RQ4]
    nxt_rega_cv = rega_to_cv(nxt_rega);
    nxt_regb_cv = regb_to_cv(nxt_regb); // [RQ7]
    nxt_fading = (nxt_state == BLFR_FADING);
  end

  // output decode, registered so every output comes from a flop
  always_ff @(posedge sys_clk_i or negedge rstn) begin
    if (!rstn) begin
      halfma_ff <= '0;
      on_ff <= 4'h0;
      rega_cv_ff <= 7'h00;
      regb_cv_ff <= 5'h00;
      fading_ff <= 1'b0;
    end else if (clk_en_i) begin
      halfma_ff <= nxt_halfma;
      on_ff <= nxt_on;
      rega_cv_ff <= nxt_rega_cv;
      regb_cv_ff <= nxt_regb_cv;
      fading_ff <= nxt_fading;
    end
  end

  // no read port: nothing here returns register contents to the host [RQ15]
  assign level_code_o = eff_ff;
  assign sink_halfma_o = halfma_ff;
  assign sink_enables_o = sinks_ff;
  assign sink_on_o = on_ff;
  assign regulator_a_code_o = rega_ff;
  assign regulator_a_cv_o = rega_cv_ff;
  assign regulator_b_code_o = regb_ff;
  assign regulator_b_cv_o = regb_cv_ff;
  assign fading_o = fading_ff;
endmodule

// [blfr_regs_asserts.sv]
`include "blfr_map.svh"

module blfr_regs_asserts
  import blfr_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `BLFR_TICK_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  // write port
  input wire logic [4:0] wr_addr_i,
  input wire logic [5:0] wr_data_i,
  input wire logic wr_stb_i,
  // outputs watched
  input wire logic [4:0] level_code_o,
  input wire blfr_pkg::blfr_halfma_t sink_halfma_o,
  input wire logic [3:0] sink_enables_o,
  input wire logic [3:0] sink_on_o,
  input wire logic [3:0] regulator_a_code_o,
  input wire logic [6:0] regulator_a_cv_o,
  input wire logic [2:0] regulator_b_code_o,
  input wire logic [4:0] regulator_b_cv_o,
  input wire logic fading_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr;
  logic [5:0] data_q;
  assign wr = wr_stb_i && clk_en_i;
  always_ff @(posedge sys_clk_i) begin
    data_q <= wr_data_i;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  a_sink_gate: assert property (sink_on_o == (sink_enables_o & {4{sink_halfma_o != 6'h00}}))
    else $error("sink on does not follow enables and current");
  a_reserved_off: assert property (level_code_o < 5'h04 |-> sink_halfma_o == 6'h00)
    else $error("reserved level gives current");
  a_half_steps: assert property (level_code_o inside {[5'h04:5'h0D]}
    |-> sink_halfma_o == {1'b0, level_code_o} - 6'h03) else $error("low level map wrong");
  a_milli_steps: assert property (level_code_o inside {[5'h0E:5'h1D]}
    |-> sink_halfma_o == {level_code_o, 1'b0} - 6'h10) else $error("mid level map wrong");
  a_enable_write: assert property (wr && wr_addr_i == 5'h01
    |=> sink_enables_o == data_q[4:1]) else $error("enable write lost");
  a_rega_volts: assert property (regulator_a_code_o inside {[4'h1:4'hA]}
    |-> regulator_a_cv_o == 7'h22 - {3'h0, regulator_a_code_o}) else $error("reg a map wrong");
  a_regb_volts: assert property (regulator_b_code_o != 3'h0
    |-> regulator_b_cv_o == 5'h13 - {2'h0, regulator_b_code_o}) else $error("reg b map wrong");
  a_fade_unit: assert property (fading_o ##1 fading_o
    |-> (level_code_o - $past(level_code_o)) inside {5'h00, 5'h01, 5'h1F})
    else $error("fade moved more than one count");
  a_step_spacing: assert property (fading_o && $changed(level_code_o) ##1 fading_o
    |-> $stable(level_code_o)) else $error("fade steps too close");
  a_fade_cancel: assert property (fading_o && wr && wr_addr_i == 5'h04 && !wr_data_i[0]
    |=> !fading_o) else $error("cancel did not stop fade");
  c_fade_start: cover property ($rose(fading_o));
  c_fade_end: cover property ($fell(fading_o));
  c_enable_write: cover property (wr && wr_addr_i == 5'h01);
endmodule

bind blfr_regs blfr_regs_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.sys_clk_i, .rstn_i,
  .clk_en_i, .wr_addr_i, .wr_data_i, .wr_stb_i, .level_code_o, .sink_halfma_o,
  .sink_enables_o, .sink_on_o, .regulator_a_code_o, .regulator_a_cv_o,
  .regulator_b_code_o, .regulator_b_cv_o, .fading_o);

// [blfr_host.sv]
module blfr_host (
  // clock
  input wire logic sys_clk_i,
  // write port toward the register bank
  output logic [4:0] wr_addr_o,
  output logic [5:0] wr_data_o,
  output logic wr_stb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_addr_o = 5'h00;
    wr_data_o = 6'h00;
    wr_stb_o = 1'b0;
  end
  task automatic wr(input logic [4:0] a, input logic [5:0] d);
    logic [5:0] m;
    m = (a == 5'h00) ? 6'h1F : (a == 5'h01) ? 6'h1E : (a == 5'h02) ? 6'h0F : 6'h07;
    if (a > 5'h04) m = 6'h3F;
    @(posedge sys_clk_i);
    wr_addr_o <= a;
    wr_data_o <= d & m;
    wr_stb_o <= 1'b1;
    @(posedge sys_clk_i);
    wr_stb_o <= 1'b0;
    // stale data would hide a late sample
    wr_data_o <= ~(d & m);
    #1;
  endtask
endmodule

// [test_backlight_ldo_fade_regs.sv]
module test_backlight_ldo_fade_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import blfr_pkg::*;
  localparam int unsigned TICK = 4;
  logic sys_clk_i, rstn_i, clk_en_i, wr_stb, fading;
  logic [4:0] wr_addr, level_code, b_cv;
  logic [5:0] wr_data;
  blfr_halfma_t halfma;
  logic [3:0] enables, sink_on, a_code;
  logic [6:0] a_cv;
  logic [2:0] b_code;
  int fail_count = 0, checks_done = 0, lvl, en, ra, rb, fad, n, ms;
  blfr_host i_host (.sys_clk_i(sys_clk_i), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .wr_stb_o(wr_stb));
  blfr_regs #(.TICK_CYCLES(TICK)) i_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .clk_en_i(clk_en_i), .wr_addr_i(wr_addr), .wr_data_i(wr_data), .wr_stb_i(wr_stb),
    .level_code_o(level_code), .sink_halfma_o(halfma), .sink_enables_o(enables),
    .sink_on_o(sink_on), .regulator_a_code_o(a_code), .regulator_a_cv_o(a_cv),
    .regulator_b_code_o(b_code), .regulator_b_cv_o(b_cv), .fading_o(fading));
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  function automatic int exp_ma(int c);
    if (c < 4) return 0;
    if (c < 14) return c - 3;
    if (c < 30) return 2 * c - 16;
    return (c == 30) ? 46 : 50;
  endfunction
  function automatic int exp_a(int c);
    if (c == 0) return 0;
    if (c < 11) return 34 - c;
    return (c == 11) ? 22 : 30 - c;
  endfunction
  task automatic summarize();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic chk_time(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h..%0h", $time, got, lo, hi);
    end
  endtask
  task automatic chk_all();
    chk(8'(level_code), 8'(lvl));
    chk(8'(halfma), 8'(exp_ma(lvl)));
    chk(8'(sink_on), 8'(exp_ma(lvl) != 0 ? en : 0));
    chk(8'(enables), 8'(en));
    chk(8'(a_code), 8'(ra));
    chk(8'(a_cv), 8'(exp_a(ra)));
    chk(8'(b_code), 8'(rb));
    chk(8'(b_cv), 8'(rb == 0 ? 0 : 19 - rb));
    chk(8'(fading), 8'(fad));
  endtask
  task automatic wait_chg(output int cyc);
    logic [4:0] old;
    old = level_code;
    cyc = 0;
    while (level_code === old && cyc < 5000) begin
      @(posedge sys_clk_i);
      #1;
      cyc++;
    end
    if (cyc >= 5000) begin
      $display("[ERR] t=%0t timeout got=%0h exp=%0h", $time, level_code, old);
      fail_count++;
      summarize();
    end
  endtask
  initial begin
    rstn_i = 1'b0;
    clk_en_i = 1'b1;
    {lvl, en, ra, rb, fad} = '0;
    void'($urandom(32'hD452FA41));
    repeat (20) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk_all();
    for (int c = 0; c < 32; c++) begin
      en = $urandom & 15;
      i_host.wr(5'h01, 6'(en << 1));
      i_host.wr(5'h00, 6'(c));
      lvl = c;
      chk_all();
    end
    for (int c = 0; c < 16; c++) begin
      ra = c;
      rb = c & 7;
      i_host.wr(5'h02, 6'(ra));
      i_host.wr(5'h03, 6'(rb));
      chk_all();
    end
    for (int a = 5; a < 32; a++) i_host.wr(5'(a), 6'($urandom));
    chk_all();
    for (int r = 0; r < 4; r++) begin
      ms = 32 - 8 * r;
      i_host.wr(5'h04, 6'h00);
      i_host.wr(5'h00, 6'h0A);
      i_host.wr(5'h04, 6'(r * 2 + 1));
      i_host.wr(5'h00, 6'h0C);
      {lvl, fad} = {32'd10, 32'd1};
      chk_all();
      i_host.wr(5'h00, 6'h14);
      wait_chg(n);
      chk_time(n + 2, (ms - 1) * TICK + 1, ms * TICK + 2);
      lvl = 11;
      chk_all();
      wait_chg(n);
      chk_time(n, ms * TICK - 1, ms * TICK + 1);
      {lvl, fad} = {32'd12, 32'd0};
      chk_all();
    end
    i_host.wr(5'h00, 6'h04);
    fad = 1;
    wait_chg(n);
    i_host.wr(5'h04, 6'h06);
    {lvl, fad} = {32'd4, 32'd0};
    chk_all();
    i_host.wr(5'h04, 6'h01);
    i_host.wr(5'h00, 6'h06);
    i_host.wr(5'h04, 6'h07);
    wait_chg(n);
    chk_time(n + 2, 7 * TICK + 1, 8 * TICK + 2);
    // a low clock enable must freeze the level and the interval count
    @(posedge sys_clk_i);
    clk_en_i <= 1'b0;
    repeat (9) @(posedge sys_clk_i);
    #1;
    {lvl, fad} = {32'd5, 32'd1};
    chk_all();
    @(posedge sys_clk_i);
    clk_en_i <= 1'b1;
    wait_chg(n);
    chk_time(n + 1, 8 * TICK - 1, 8 * TICK + 1);
    {lvl, fad} = {32'd6, 32'd0};
    chk_all();
    summarize();
  end
endmodule
